// ### pkg/group_ctl_consts.vh
`ifndef GROUP_CTL_CONSTS_VH
`define GROUP_CTL_CONSTS_VH
// register offsets (word index on the plain port)
`define ADDR_W 4
`define A_COMMAND 4'h0
`define A_ARG 4'h1
`define A_STATUS 4'h2
`define A_ARM_SRC 4'h3
`define A_ZERO 4'h4
`define A_CAL_VALUE 4'h5
`define A_CAL_OFFSET 4'h6
`define A_SLOPE 4'h7
`define A_CAL_RESULT 4'h8
// command codes written to the command register
`define CMD_W 4
`define CMD_ABORT 4'h1
`define CMD_ARM_SLOPE 4'h2
`define CMD_ARM_SOURCE 4'h3
`define CMD_ARM_ZERO 4'h4
`define CMD_START 4'h5
`define CMD_CAL_VALUE 4'h6
`define CMD_CAL_ZERO 4'h7
`define CMD_STATUS_QUERY 4'h8
// argument register fields
`define ARG_GROUPS 3:0
`define ARG_VALUE 4
`define ARG_VALUE_GIVEN 5
`define ARG_CHAN 9:6
`define ARG_CHAN_GIVEN 10
`define ARG_RANGE 13:11
`define ARG_SEQ 28:14
// range codes: 0 means every range, 1..7 = 0.2,0.5,1,2,5,10,20
`define RANGE_ALL 3'h0
`define RANGE_COUNT 3'h7
`define GROUP_ONE 4'h1
`define CHAN_ONE 4'h0
// timing
`define ZERO_CYCLES 8'h0F
`define CAL_CYCLES 16'h03FF
`define BLINK_BIT 4
`define BLINK_W 5
`endif

// ### rtl/group_arm_abort_calibrate_control.v
// What this block does
// R1: abort disarms selected groups, halts sampling
// R2: abort opens selected groups' input relays
// R3: no group given means group 1
// R4: latch arm edge, apply on start
// R5: external source: start enables arm input
// R6: arm_internally_at_once source arms at once; reset default
// R7: zero setting clears memory before arming
// R8: missing boolean means 0; reset 0 (the arm source command reads the value bit even when it is not given)
// R9: sequence and index fields accepted, ignored
// R10: armed indicator follows internal armed only
// R11: one arm input and edge shared
// R12: gain+offset or offset-only calibration requests
// R13: range zero calibrates every offset range
// R14: range rounds up to implemented range
// R15: calibration resets module, restores, keeps errors (the start clears the cal_error bit of the channel calibrated)
// R16: during calibration only status queries accepted
// R17: error indicator blinks during calibration
// R18: completion via status, complete bit, request
// R19: report stored offset and gain values
// R20: no channel given means channel 1
// R21: four groups of four consecutive channels
// R22: abort cancels a pending external arm wait
//
// Local design decisions: the register offsets and strobed register access.
`include "group_ctl_consts.vh"
module group_arm_abort_calibrate_control (
  input wire clock,
  input wire resetn,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ext_arm_in,
  input wire [3:0] sample_done,
  output reg [3:0] armed,
  output reg [3:0] sampling,
  output reg [15:0] relay_closed,
  output reg [3:0] mem_zero,
  output reg armed_led,
  output reg error_led,
  output reg cal_busy,
  output reg op_complete,
  output reg service_request,
  output reg [15:0] cal_error
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ZERO = 3'b010;
  localparam ST_CAL = 3'b100;

  reg [31:0] arg;
  reg slope_neg;
  reg slope_live;
  reg [3:0] src_ext;
  reg [3:0] zero_en;
  reg [3:0] ext_wait;
  reg [3:0] zero_pend;
  reg [7:0] zero_cnt;
  reg [2:0] state;
  reg [15:0] cal_cnt;
  reg [4:0] blink;
  reg cal_gain;
  reg [3:0] cal_chan;
  reg [2:0] cal_range;
  reg [2:0] cal_range_now;
  reg cal_done;
  reg [15:0] offset_mem [0:15];
  reg [15:0] gain_mem [0:15];
  reg ext_prev;
  reg [15:0] offset_q;
  reg [15:0] gain_q;
  integer i;

  wire [3:0] groups;
  wire [3:0] chan;
  wire bool_arg;
  wire [14:0] index_field_a;
  wire cmd;
  wire [3:0] op;
  wire cmd_ok;
  wire edge_hit;
  wire cal_start;

  ////////////////////////////////////////////////////////////////////////////////
  assign groups = (arg[`ARG_GROUPS] == 4'h0) ? `GROUP_ONE : arg[`ARG_GROUPS]; // see R3
  assign chan = arg[`ARG_CHAN_GIVEN] ? arg[`ARG_CHAN] : `CHAN_ONE; // see R20
  assign bool_arg = arg[`ARG_VALUE_GIVEN] & arg[`ARG_VALUE]; // see R8
  // index fields travel in arg; no control logic reads them
  assign index_field_a = arg[`ARG_SEQ]; // see R9
  assign cmd = wr && addr == `A_COMMAND;
  assign op = wdata[3:0];
  // during calibration only the status query passes; the rest drop silently
  assign cmd_ok = cmd && (state == ST_IDLE || op == `CMD_STATUS_QUERY); // see R16
  assign edge_hit = slope_live ? (ext_prev & ~ext_arm_in) : (~ext_prev & ext_arm_in); // see R11
  assign cal_start = cmd_ok && state == ST_IDLE && (op == `CMD_CAL_VALUE || op == `CMD_CAL_ZERO);

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arg <= 32'h0000_0000;
      slope_neg <= 1'b0;
      slope_live <= 1'b0;
      src_ext <= 4'h0;
      zero_en <= 4'h0;
      ext_wait <= 4'h0;
      zero_pend <= 4'h0;
      zero_cnt <= 8'h00;
      armed <= 4'h0;
      sampling <= 4'h0;
      relay_closed <= 16'h0000;
      mem_zero <= 4'h0;
      ext_prev <= 1'b0;
      state <= ST_IDLE;
      cal_cnt <= 16'h0000;
      blink <= 5'h00;
      cal_gain <= 1'b0;
      cal_chan <= 4'h0;
      cal_range <= 3'h0;
      cal_range_now <= 3'h0;
      cal_done <= 1'b0;
      cal_error <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        offset_mem[i] <= 16'h0000;
        gain_mem[i] <= 16'h0000;
      end
    end else begin
      ext_prev <= ext_arm_in;
      blink <= blink + 5'h01;
      if (wr && addr == `A_ARG && state == ST_IDLE) begin
        arg <= wdata;
      end
      // groups waiting on the shared input arm on the selected edge
      for (i = 0; i < 4; i = i + 1) begin
        if (ext_wait[i] && edge_hit && !zero_pend[i]) begin
          armed[i] <= 1'b1; // see R5
          ext_wait[i] <= 1'b0;
          sampling[i] <= 1'b1;
        end
        if (sample_done[i]) begin
          sampling[i] <= 1'b0;
        end
      end
      if (zero_pend != 4'h0) begin
        mem_zero <= zero_pend;
        if (zero_cnt == `ZERO_CYCLES) begin
          zero_pend <= 4'h0;
          mem_zero <= 4'h0;
          zero_cnt <= 8'h00;
          for (i = 0; i < 4; i = i + 1) begin
            if (zero_pend[i] && !src_ext[i]) begin
              armed[i] <= 1'b1; // see R7
              sampling[i] <= 1'b1;
            end
          end
        end else begin
          zero_cnt <= zero_cnt + 8'h01;
        end
      end
      if (cmd_ok && state == ST_IDLE) begin
        case (op)
          `CMD_ABORT: begin
            for (i = 0; i < 4; i = i + 1) begin
              if (groups[i]) begin
                armed[i] <= 1'b0; // see R1
                sampling[i] <= 1'b0;
                ext_wait[i] <= 1'b0; // see R22
                zero_pend[i] <= 1'b0;
                relay_closed[4*i +: 4] <= 4'h0; // see R2 R21
              end
            end
          end
          `CMD_ARM_SLOPE: begin
            slope_neg <= bool_arg; // see R4
          end
          `CMD_ARM_SOURCE: begin
            src_ext <= (src_ext & ~groups) | (groups & {4{arg[`ARG_VALUE]}});
          end
          `CMD_ARM_ZERO: begin
            zero_en <= (zero_en & ~groups) | (groups & {4{bool_arg}}); // see R8
          end
          `CMD_START: begin
            slope_live <= slope_neg; // see R4 R11
            for (i = 0; i < 4; i = i + 1) begin
              if (groups[i]) begin
                relay_closed[4*i +: 4] <= 4'hF;
                zero_pend[i] <= zero_en[i]; // see R7
                if (zero_en[i]) begin
                  // a live group must not stay armed while its memory is wiped
                  armed[i] <= 1'b0; // see R7
                  sampling[i] <= 1'b0;
                end
                if (src_ext[i]) begin
                  ext_wait[i] <= 1'b1; // see R5
                end else if (!zero_en[i]) begin
                  armed[i] <= 1'b1; // see R6
                  sampling[i] <= 1'b1;
                end
              end
            end
          end
          default: begin
          end
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (cal_start) begin
            // module reset before calibrating
            slope_neg <= 1'b0; // see R15
            slope_live <= 1'b0;
            src_ext <= 4'h0;
            zero_en <= 4'h0;
            ext_wait <= 4'h0;
            zero_pend <= 4'h0;
            armed <= 4'h0;
            sampling <= 4'h0;
            relay_closed <= 16'h0000;
            cal_gain <= (op == `CMD_CAL_VALUE); // see R12
            cal_chan <= chan;
            cal_range <= arg[`ARG_RANGE]; // see R14
            cal_range_now <= (arg[`ARG_RANGE] == `RANGE_ALL) ? 3'h1 : arg[`ARG_RANGE]; // see R13
            cal_done <= 1'b0;
            cal_error[chan] <= 1'b0;
            cal_cnt <= 16'h0000;
            // blink phase restarts so the indicator moves soon after the start
            blink <= 5'h00; // see R17
            state <= ST_CAL;
          end
        end
        ST_CAL: begin
          cal_cnt <= cal_cnt + 16'h0001;
          if (cal_cnt == `CAL_CYCLES) begin
            cal_cnt <= 16'h0000;
            offset_mem[cal_chan] <= {13'h0000, cal_range_now}; // see R12
            if (cal_gain) begin
              gain_mem[cal_chan] <= cal_cnt;
            end
            if (cal_range == `RANGE_ALL && cal_range_now != `RANGE_COUNT) begin
              cal_range_now <= cal_range_now + 3'h1; // see R13
            end else begin
              state <= ST_ZERO;
            end
          end
        end
        ST_ZERO: begin
          // back to reset state; cal_error survives
          armed <= 4'h0; // see R15
          sampling <= 4'h0;
          relay_closed <= 16'h0000;
          ext_wait <= 4'h0;
          zero_pend <= 4'h0;
          slope_live <= 1'b0;
          slope_neg <= 1'b0;
          src_ext <= 4'h0;
          zero_en <= 4'h0;
          cal_done <= 1'b1; // see R18
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_led <= 1'b0;
      error_led <= 1'b0;
      cal_busy <= 1'b0;
      op_complete <= 1'b0;
      service_request <= 1'b0;
    end else begin
      armed_led <= |armed; // see R10
      error_led <= (state != ST_IDLE) & blink[`BLINK_BIT]; // see R17
      cal_busy <= (state != ST_IDLE);
      // completion is sticky until the status query clears it; set wins
      if (state == ST_ZERO) begin
        op_complete <= 1'b1; // see R18
        service_request <= 1'b1;
      end else if (cmd_ok && op == `CMD_STATUS_QUERY) begin
        op_complete <= 1'b0;
        service_request <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stored values mirrored a cycle behind the channel select
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      offset_q <= 16'h0000;
      gain_q <= 16'h0000;
    end else begin
      offset_q <= offset_mem[chan];
      gain_q <= gain_mem[chan];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `A_ARG: begin
          rdata <= arg;
        end
        `A_STATUS: begin
          rdata <= {22'h00_0000, cal_done, cal_busy, armed, ext_wait}; // see R18
        end
        `A_ARM_SRC: begin
          rdata <= {28'h000_0000, src_ext};
        end
        `A_ZERO: begin
          rdata <= {28'h000_0000, zero_en};
        end
        `A_CAL_VALUE: begin
          rdata <= {offset_mem[chan], gain_mem[chan]}; // see R19
        end
        `A_CAL_OFFSET: begin
          rdata <= {16'h0000, offset_mem[chan]}; // see R19
        end
        `A_SLOPE: begin
          rdata <= {31'h0000_0000, slope_neg};
        end
        `A_CAL_RESULT: begin
          rdata <= {cal_error, offset_q};
        end
        default: begin
          rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// ### verification/group_ctl_properties.sv
`include "group_ctl_consts.vh"
module group_ctl_properties (
  input wire clock,
  input wire resetn,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [3:0] armed,
  input wire [3:0] sampling,
  input wire [15:0] relay_closed,
  input wire [3:0] mem_zero,
  input wire armed_led,
  input wire error_led,
  input wire cal_busy,
  input wire op_complete,
  input wire service_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // shadow of the argument word, needed to know which groups a command selects
  reg [31:0] arg_q;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) arg_q <= 32'h0000_0000;
    else if (wr && addr == `A_ARG) arg_q <= wdata;
  end
  wire [3:0] sel = (arg_q[3:0] == 4'h0) ? 4'h1 : arg_q[3:0];
  wire cmdw = wr && addr == `A_COMMAND && !cal_busy;
  //////////////////////////////////////////////////////////////////////
  a_abort_stops: assert property (cmdw && wdata[3:0] == `CMD_ABORT |=> ((armed | sampling) & sel) == 4'h0)
    else $error("abort left a group running");
  a_led_follows: assert property (armed_led == $past(|armed))
    else $error("armed indicator off internal state");
  a_busy_refuses: assert property (wr && addr == `A_COMMAND && cal_busy |=> armed == 4'h0 ##1 armed == 4'h0)
    else $error("command acted during calibration");
  a_blink_runs: assert property ($rose(cal_busy) |-> ##[1:70] $changed(error_led))
    else $error("error indicator not blinking");
  a_done_flags: assert property ($fell(cal_busy) |-> ##[0:2] (op_complete && service_request))
    else $error("completion not reported");
  a_cal_resets: assert property ($rose(cal_busy) |-> ##[0:2] (armed == 4'h0 && relay_closed == 16'h0000))
    else $error("calibration did not reset module");
  a_zero_first: assert property ((mem_zero & armed) == 4'h0)
    else $error("armed while memory zeroing");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  c_cal_done: cover property ($fell(cal_busy));
  c_abort: cover property (cmdw && wdata[3:0] == `CMD_ABORT);
  c_armed: cover property ($rose(armed_led));
endmodule

// ### verification/bus_commander.sv
module bus_commander (
  input wire clock,
  input wire [31:0] rdata,
  output logic [3:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  output logic ext_arm_in,
  output logic [3:0] sample_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'h0;
    rd = 1'h0;
    ext_arm_in = 1'h0;
    sample_done = 4'h0;
  end
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
    // stale data must not look valid once released
    wdata <= ~d;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    // read data stand only in this cycle; take them mid-cycle, clear of the edge
    @(negedge clock);
    d = rdata;
  endtask
endmodule

// ### verification/tb_group_arm_abort_calibrate_control.sv
`include "group_ctl_consts.vh"
module tb_group_arm_abort_calibrate_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  wire [3:0] addr, armed, sampling, mem_zero, sample_done;
  wire [31:0] wdata, rdata;
  wire wr, rd, ext_arm_in, armed_led, error_led, cal_busy, op_complete, service_request;
  wire [15:0] relay_closed, cal_error;
  integer seed = 53;
  integer failures = 0;
  integer checks_done = 0;
  logic [31:0] v;
  logic [3:0] g;
  logic seen;
  always #4 clock = ~clock;
  bus_commander p (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .ext_arm_in(ext_arm_in), .sample_done(sample_done));
  group_arm_abort_calibrate_control dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_arm_in(ext_arm_in), .sample_done(sample_done), .armed(armed),
    .sampling(sampling), .relay_closed(relay_closed), .mem_zero(mem_zero), .armed_led(armed_led),
    .error_led(error_led), .cal_busy(cal_busy), .op_complete(op_complete),
    .service_request(service_request), .cal_error(cal_error));
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // random sequence and index field rides along on every command
  task cmd(input logic [3:0] op, input logic [31:0] a);
    p.wr_reg(`A_ARG, a | 32'h0000_4000 | ($random(seed) & 32'h1FFF_C000));
    p.wr_reg(`A_COMMAND, 32'(op));
    repeat (3) @(posedge clock);
  endtask
  task conclude;
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    conclude;
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    p.rd_reg(`A_SLOPE, v);
    chk(v, 32'h0000_0000);
    p.rd_reg(`A_ARM_SRC, v);
    chk(v, 32'h0000_0000);
    p.rd_reg(`A_ZERO, v);
    chk(v, 32'h0000_0000);
    g = 4'($random(seed)) | 4'h2;
    cmd(`CMD_START, 32'(g));
    chk(32'(armed), 32'(g));
    chk(32'(armed_led), 32'h0000_0001);
    cmd(`CMD_ABORT, 32'h0000_0000);
    chk(32'(armed), 32'(g & 4'hE));
    chk(32'(relay_closed[3:0]), 32'h0000_0000);
    cmd(`CMD_ABORT, 32'h0000_000F);
    chk(32'({armed, sampling, relay_closed}), 32'h0000_0000);
    cmd(`CMD_ARM_ZERO, 32'h0000_0032);
    p.rd_reg(`A_ZERO, v);
    chk(v, 32'h0000_0002);
    cmd(`CMD_START, 32'h0000_0002);
    seen = mem_zero[1];
    repeat (40) @(posedge clock) seen = seen | mem_zero[1];
    chk(32'({seen, armed}), 32'h0000_0012);
    cmd(`CMD_ARM_ZERO, 32'h0000_0012);
    p.rd_reg(`A_ZERO, v);
    chk(v, 32'h0000_0000);
    cmd(`CMD_ABORT, 32'h0000_000F);
    cmd(`CMD_ARM_SOURCE, 32'h0000_0038);
    cmd(`CMD_ARM_SLOPE, 32'h0000_0030);
    cmd(`CMD_START, 32'h0000_0008);
    chk(32'(armed), 32'h0000_0000);
    p.ext_arm_in <= 1'h1;
    repeat (4) @(posedge clock);
    chk(32'(armed), 32'h0000_0000);
    p.ext_arm_in <= 1'h0;
    repeat (4) @(posedge clock);
    chk(32'({armed_led, armed}), 32'h0000_0018);
    cmd(`CMD_ABORT, 32'h0000_0008);
    cmd(`CMD_START, 32'h0000_0008);
    cmd(`CMD_ABORT, 32'h0000_0008);
    p.ext_arm_in <= 1'h1;
    repeat (4) @(posedge clock);
    p.ext_arm_in <= 1'h0;
    repeat (4) @(posedge clock);
    chk(32'(armed), 32'h0000_0000);
    cmd(`CMD_CAL_ZERO, 32'h0000_1C00 | ($random(seed) & 32'h0000_03C0));
    chk(32'(cal_busy), 32'h0000_0001);
    cmd(`CMD_START, 32'h0000_000F);
    chk(32'(armed), 32'h0000_0000);
    for (int i = 0; i < 3000 && cal_busy !== 1'h0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk(32'({op_complete, service_request, armed}), 32'h0000_0030);
    p.rd_reg(`A_STATUS, v);
    chk(v, 32'h0000_0200);
    cmd(`CMD_STATUS_QUERY, 32'h0000_0000);
    chk(32'(op_complete), 32'h0000_0000);
    conclude;
  end
endmodule
bind group_arm_abort_calibrate_control group_ctl_properties chk_i (.clock(clock), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .armed(armed), .sampling(sampling),
  .relay_closed(relay_closed), .mem_zero(mem_zero), .armed_led(armed_led), .error_led(error_led),
  .cal_busy(cal_busy), .op_complete(op_complete), .service_request(service_request));
